// ---- rtl/acf_pkg.sv ----
// constants, field layout and types for the adc configuration and fault registers
package acf_pkg;

    // ------------------------------------------------------------------
    // register addresses (word bits 15:12)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CFG1  = 4'h1;  // conversion_and_power_config
    localparam logic [3:0] ADDR_CFG2  = 4'h2;  // output_and_reset_control
    localparam logic [3:0] ADDR_FAULT = 4'h3;  // fault_status

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ADDR_MSB     = 15;  // address field top bit
    localparam int ADDR_LSB     = 12;  // address field low bit
    localparam int OSMODE_BIT   = 9;   // rolling average enable
    localparam int OSR_MSB      = 8;   // ratio field top bit
    localparam int OSR_LSB      = 6;   // ratio field low bit
    localparam int CRCW_BIT     = 5;   // write check enable
    localparam int CRCR_BIT     = 4;   // read check enable
    localparam int ALERTEN_BIT  = 3;   // lane b carries the flag in one lane mode
    localparam int RES_BIT      = 2;   // resolution boost
    localparam int REFERENCE_SOURCE_SELECT_BIT   = 1;   // reference select
    localparam int POWER_DOWN_MODE_BIT    = 0;   // shutdown
    localparam int LANESEL_BIT  = 8;   // one lane when set
    localparam int WCF_BIT      = 9;   // write check failure flag
    localparam int LOADF_BIT    = 8;   // load failure flag
    localparam int CFG1_WIDTH   = 10;  // stored bits of cfg1

    // ------------------------------------------------------------------
    // reset values and command codes
    // ------------------------------------------------------------------
    localparam logic [CFG1_WIDTH-1:0] CFG1_RESET = 10'h000;
    localparam logic                  LANE_RESET = 1'b0;
    localparam logic [7:0]            CMD_SOFT   = 8'h3C;
    localparam logic [7:0]            CMD_HARD   = 8'hFF;
    localparam logic [2:0]            OSR_X2     = 3'h1;
    localparam logic [2:0]            OSR_X4     = 3'h2;
    localparam logic [2:0]            OSR_X8     = 3'h3;
    localparam logic [4:0]            WIDTH_NORM = 5'h10;  // 16 bit results
    localparam logic [4:0]            WIDTH_BOOST = 5'h12; // two more bits
    localparam logic [7:0]            CHECK_POLY = 8'h07;  // check code polynomial
    localparam logic [7:0]            CHECK_INIT = 8'h00;  // check code seed

    // ------------------------------------------------------------------
    // frame lengths: write flag + word, optionally + check byte
    // ------------------------------------------------------------------
    localparam logic [4:0] FRAME_PLAIN_BITS = 5'h11;  // 17 bits
    localparam logic [4:0] FRAME_CHECK_BITS = 5'h19;  // 25 bits

    // ------------------------------------------------------------------
    // timing of the startup configuration load
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;  // 200 MHz
    localparam int LOAD_TIME_NS  = 100;   // least load time
    localparam int LOAD_CYCLES   = (LOAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] LOAD_LAST = 8'(LOAD_CYCLES - 1);

    // load sequencer states
    typedef enum logic [1:0] {
        ACF_LD_RUN  = 2'b01,
        ACF_LD_DONE = 2'b10
    } acf_load_t;

endpackage

// ---- rtl/acf_chk_if.sv ----
// carrier between the frame logic and the check code generator
`timescale 1ns/1ps
interface acf_chk_if;
    logic [15:0] word;  // received register word
    logic [7:0]  code;  // expected check byte
    modport calc (input word, output code);
    modport user (output word, input code);
endinterface

// ---- rtl/acf_check_gen.sv ----
// combinational 8 bit check code over one register word
`timescale 1ns/1ps
module acf_check_gen
    import acf_pkg::*;
(
    acf_chk_if.calc chk
);
    // ------------------------------------------------------------------
    // bitwise division, msb first; pure logic, no state to reset
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] acc;
        logic       fb;
        acc = CHECK_INIT;
        fb  = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            fb  = acc[7] ^ chk.word[i];
            acc = {acc[6:0], 1'b0};
            if (fb) begin
                acc = acc ^ CHECK_POLY;
            end
        end
        chk.code = acc;
    end
endmodule

// ---- rtl/acf_regs.sv ----
// configuration and fault registers behind the serial register port
`timescale 1ns/1ps
module acf_regs
    import acf_pkg::*;
(
    input  wire logic       clk,                       // 200 MHz system clock
    input  wire logic       reset,                     // synchronous, active high
    input  wire logic       cs_n,                      // frame select pin, low active
    input  wire logic       sclk,                      // serial clock pin
    input  wire logic       sdi,                       // serial data in pin
    input  wire logic       config_load_ok,            // internal load result
    output logic            serial_out_lane_a,         // lane a pin
    output logic            serial_out_lane_b_or_flag, // lane b or fault flag pin
    output logic            power_down_mode,           // shutdown requested
    output logic            reference_source_select,   // 1 external reference
    output logic            resolution_boost_active,   // boost in force
    output logic [4:0]      result_width,              // bits per result
    output logic [3:0]      oversample_factor,         // 1, 2, 4 or 8
    output logic            two_lane_mode,             // data split over lanes
    output logic            lane_b_is_flag,            // lane b shows fault flag
    output logic            accum_flush,               // pulse: drop accumulations
    output logic            hard_reset_pulse,          // pulse: all blocks reset
    output logic            config_ready               // startup load finished
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [CFG1_WIDTH-1:0] cfg1_reg;      // conversion and power fields
    logic                  lane_sel_reg;  // one lane when set
    logic                  wcf_reg;       // write check failure flag
    logic                  loadf_reg;     // load failure flag
    logic                  soft_reg;      // soft reset in progress
    logic                  hard_reg;      // hard reset in progress
    acf_load_t             load_state;    // startup load sequencer
    logic [7:0]            load_cnt_reg;  // load timer
    logic [2:0]            cs_sync;       // two stages plus edge history
    logic [2:0]            sclk_sync;     // two stages plus edge history
    logic [1:0]            sdi_sync;      // two stages
    logic [4:0]            bit_cnt_reg;   // bits seen in this frame
    logic [24:0]           in_sh_reg;     // incoming frame
    logic [15:0]           out_sh_reg;    // readback word being sent
    logic                  lane_a_reg;    // lane a level
    logic                  lane_b_reg;    // lane b level
    logic                  res_act_reg;   // registered boost state
    logic [4:0]            width_reg;     // registered result width
    logic [3:0]            factor_reg;    // registered ratio

    acf_chk_if chk ();

    // ------------------------------------------------------------------
    // check code generator
    // ------------------------------------------------------------------
    acf_check_gen u_check (
        .chk (chk.calc)
    );

    // ------------------------------------------------------------------
    // edges of the synchronised pins
    // ------------------------------------------------------------------
    wire cs_high    = cs_sync[1];
    wire cs_rise    = cs_sync[1] & ~cs_sync[2];
    wire cs_fall    = ~cs_sync[1] & cs_sync[2];
    wire sclk_rise  = sclk_sync[1] & ~sclk_sync[2] & ~cs_high;
    wire sclk_fall  = ~sclk_sync[1] & sclk_sync[2] & ~cs_high;

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    wire        len_plain = (bit_cnt_reg == FRAME_PLAIN_BITS);
    wire        len_check = (bit_cnt_reg == FRAME_CHECK_BITS);
    wire [16:0] frame     = len_check ? in_sh_reg[24:8] : in_sh_reg[16:0];
    wire        is_write  = frame[16];
    wire [15:0] word      = frame[15:0];
    wire [3:0]  addr      = word[ADDR_MSB:ADDR_LSB];
    wire        hit_cfg1  = (addr == ADDR_CFG1);
    wire        hit_cfg2  = (addr == ADDR_CFG2);
    wire        hit_fault = (addr == ADDR_FAULT);
    wire [7:0]  rst_cmd   = word[7:0];

    // a check is owed while checking is on, or when this write turns it on
    wire chk_needed = cfg1_reg[CRCW_BIT] | (hit_cfg1 & word[CRCW_BIT]);
    wire chk_ok     = len_check & (chk.code == in_sh_reg[7:0]);
    assign chk.word = word;

    // only complete frames count; lengths other than 17 or 25 bits are dropped silently
    wire frame_done = cs_rise & (len_plain | len_check);
    wire wr_reject  = frame_done & is_write & chk_needed & ~chk_ok;
    wire wr_take    = frame_done & is_write & ~(chk_needed & ~chk_ok);
    wire rd_take    = frame_done & ~is_write;

    // reset codes; any other value starts no reset, and the write still sets the lane select
    wire soft_cmd = wr_take & hit_cfg2 & (rst_cmd == CMD_SOFT);
    wire hard_cmd = wr_take & hit_cfg2 & (rst_cmd == CMD_HARD);

    // block reset: pin reset or a commanded hard reset one cycle later
    wire blk_rst = reset | hard_reg;

    // ------------------------------------------------------------------
    // readback words; the reset field never holds a value
    // ------------------------------------------------------------------
    wire [15:0] rd_cfg1  = {ADDR_CFG1, 2'b00, cfg1_reg};
    wire [15:0] rd_cfg2  = {ADDR_CFG2, 3'b000, lane_sel_reg, 8'h00};
    wire [15:0] rd_fault = {ADDR_FAULT, 2'b00, wcf_reg, loadf_reg, 8'h00};
    wire [15:0] rd_word  = hit_cfg1  ? rd_cfg1  :
                           hit_cfg2  ? rd_cfg2  :
                           hit_fault ? rd_fault : {addr, 12'h000};

    // ------------------------------------------------------------------
    // effective conversion settings
    // ------------------------------------------------------------------
    wire [2:0] oversample_ratio        = cfg1_reg[OSR_MSB:OSR_LSB];
    wire       osr_on     = (oversample_ratio == OSR_X2) | (oversample_ratio == OSR_X4) | (oversample_ratio == OSR_X8);
    wire       boost_on   = cfg1_reg[RES_BIT] & osr_on;
    wire [4:0] width_next = boost_on ? WIDTH_BOOST : WIDTH_NORM;
    wire [3:0] factor_next = (oversample_ratio == OSR_X2) ? 4'h2 :
                             (oversample_ratio == OSR_X4) ? 4'h4 :
                             (oversample_ratio == OSR_X8) ? 4'h8 : 4'h1;
    wire       flag_mode  = lane_sel_reg & cfg1_reg[ALERTEN_BIT];
    wire       fault_any  = wcf_reg | loadf_reg;

    // ------------------------------------------------------------------
    // pin synchronisers; stage 0 is read only by stage 1
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_sync   <= 3'h7;
            sclk_sync <= 3'h0;
            sdi_sync  <= 2'h0;
        end else begin
            cs_sync   <= {cs_sync[1:0], cs_n};
            sclk_sync <= {sclk_sync[1:0], sclk};
            sdi_sync  <= {sdi_sync[0], sdi};
        end
    end

    // ------------------------------------------------------------------
    // input shifter: sample on sclk rise, count saturates
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst || soft_reg || cs_fall) begin
            bit_cnt_reg <= 5'h00;
            in_sh_reg   <= 25'h0000000;
        end else if (sclk_rise) begin
            in_sh_reg <= {in_sh_reg[23:0], sdi_sync[1]};
            if (bit_cnt_reg != 5'h1F) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // conversion and power config
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            cfg1_reg <= CFG1_RESET;
        end else if (wr_take && hit_cfg1) begin
            cfg1_reg <= word[CFG1_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // output and reset control; the command byte is never stored
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            lane_sel_reg <= LANE_RESET;
        end else if (wr_take && hit_cfg2 && !hard_cmd) begin
            lane_sel_reg <= word[LANESEL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // reset strobes, one cycle each
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_reg <= 1'b0;
            hard_reg <= 1'b0;
        end else begin
            soft_reg <= soft_cmd & ~hard_reg;
            hard_reg <= hard_cmd & ~hard_reg;
        end
    end

    // ------------------------------------------------------------------
    // write check flag: a new failure beats a clearing read
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            wcf_reg <= 1'b0;
        end else if (wr_reject) begin
            wcf_reg <= 1'b1;
        end else if ((rd_take && hit_fault) || soft_reg) begin
            wcf_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // startup load sequencer; a hard reset starts it over
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            load_state   <= ACF_LD_RUN;
            load_cnt_reg <= 8'h00;
            loadf_reg    <= 1'b0;
        end else begin
            case (load_state)
                ACF_LD_RUN: begin
                    if (load_cnt_reg == LOAD_LAST) begin
                        loadf_reg  <= ~config_load_ok;
                        load_state <= ACF_LD_DONE;
                    end else begin
                        load_cnt_reg <= load_cnt_reg + 8'h01;
                    end
                end
                ACF_LD_DONE: begin
                    load_state <= ACF_LD_DONE;    // reads leave the flag alone
                end
                default: begin
                    load_state <= ACF_LD_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // readback shifter: captured at a read, sent in the next frame
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst || soft_reg) begin
            out_sh_reg <= 16'h0000;
        end else if (rd_take) begin
            out_sh_reg <= rd_word;
        end else if (sclk_fall) begin
            out_sh_reg <= {out_sh_reg[14:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // lane a: high half in two lane mode, whole word in one lane mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            lane_a_reg <= 1'b0;
        end else if (cs_fall) begin
            lane_a_reg <= out_sh_reg[15];
        end else if (sclk_fall) begin
            lane_a_reg <= out_sh_reg[14];
        end
    end

    // ------------------------------------------------------------------
    // lane b: low half, idle low, or the fault flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            lane_b_reg <= 1'b0;
        end else if (flag_mode) begin
            lane_b_reg <= fault_any;
        end else if (lane_sel_reg) begin
            lane_b_reg <= 1'b0;
        end else if (cs_fall) begin
            lane_b_reg <= out_sh_reg[7];
        end else if (sclk_fall) begin
            lane_b_reg <= out_sh_reg[6];
        end
    end

    // ------------------------------------------------------------------
    // registered conversion settings for the datapath
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            res_act_reg <= 1'b0;
            width_reg   <= WIDTH_NORM;
            factor_reg  <= 4'h1;
        end else begin
            res_act_reg <= boost_on;
            width_reg   <= width_next;
            factor_reg  <= factor_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign serial_out_lane_a         = lane_a_reg;
    assign serial_out_lane_b_or_flag = lane_b_reg;
    assign power_down_mode           = cfg1_reg[POWER_DOWN_MODE_BIT];
    assign reference_source_select   = cfg1_reg[REFERENCE_SOURCE_SELECT_BIT];
    assign resolution_boost_active   = res_act_reg;
    assign result_width              = width_reg;
    assign oversample_factor         = factor_reg;
    assign two_lane_mode             = ~lane_sel_reg;
    assign lane_b_is_flag            = flag_mode;
    assign accum_flush               = soft_reg | hard_reg;
    assign hard_reset_pulse          = hard_reg;
    assign config_ready              = (load_state == ACF_LD_DONE);

endmodule

// ---- testbench/acf_host_model.sv ----
// host processor model driving the serial register port
`timescale 1ns/1ps
module acf_host_model (
    input  wire logic clk,    // system clock
    output logic      cs_n,   // frame select, low active
    output logic      sclk,   // stands low outside frames
    output logic      sdi,    // data to the device
    input  wire logic lane_a, // readback lane a
    input  wire logic lane_b  // readback lane b or flag
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // crc8 poly 07 seed 00 msb first, kept apart from the design's generator
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // one frame; half periods of 4 clk clear the 3 clk synchroniser need
    task automatic frame(input logic wr, input logic [15:0] w, input logic chk,
                         output logic [15:0] ra, output logic [15:0] rb);
        logic [24:0] bits;
        bits = {wr, w, crc8(w)};
        ra = 16'h0000;
        rb = 16'h0000;
        @(negedge clk) cs_n = 1'b0;
        for (int i = 0; i < (chk ? 25 : 17); i++) begin
            sdi = bits[24-i];
            repeat (4) @(negedge clk);
            if (i < 16) begin
                ra[15-i] = lane_a;
                rb[15-i] = lane_b;
            end
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        sdi  = ~sdi; // released line shows no stale bit
        repeat (8) @(negedge clk);
    endtask
endmodule

// ---- testbench/acf_regs_checker.sv ----
// port assertions for the configuration and fault registers
`timescale 1ns/1ps
module acf_regs_checker
    import acf_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       resolution_boost_active,
    input wire logic [4:0] result_width,
    input wire logic [3:0] oversample_factor,
    input wire logic       two_lane_mode,
    input wire logic       lane_b_is_flag,
    input wire logic       accum_flush,
    input wire logic       hard_reset_pulse,
    input wire logic       config_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_boost_width: assert property (
        result_width == (resolution_boost_active ? WIDTH_BOOST : WIDTH_NORM))
        else $error("result width disagrees with boost");
    a_boost_ratio: assert property (
        resolution_boost_active |-> oversample_factor != 4'h1)
        else $error("boost active without ratio");
    a_flag_one_lane: assert property (lane_b_is_flag |-> !two_lane_mode)
        else $error("flag on lane b in two lane mode");
    a_hard_flush: assert property (hard_reset_pulse |-> accum_flush)
        else $error("hard reset without flush");
    a_flush_once: assert property (accum_flush |=> !accum_flush)
        else $error("flush pulse too long");
    a_hard_reload: assert property (hard_reset_pulse |-> ##[0:2] !config_ready)
        else $error("load not restarted");
    a_load_wait: assert property ($fell(reset) |-> !config_ready [*8])
        else $error("load finished too early");
    a_hard_default: assert property (hard_reset_pulse |-> ##[1:3] two_lane_mode)
        else $error("lane select not restored");
    c_hard: cover property (hard_reset_pulse);
    c_soft: cover property (accum_flush && !hard_reset_pulse);
    c_flag: cover property (lane_b_is_flag);
endmodule
bind acf_regs acf_regs_checker u_chk (.*);

// ---- testbench/acf_regs_tb.sv ----
// self-checking bench for the configuration and fault registers
`timescale 1ns/1ps
module acf_regs_tb;
    logic clk, reset, config_load_ok, cs_n, sclk, sdi, config_ready;
    logic serial_out_lane_a, serial_out_lane_b_or_flag, power_down_mode;
    logic reference_source_select, resolution_boost_active, two_lane_mode;
    logic lane_b_is_flag, accum_flush, hard_reset_pulse;
    logic [4:0]  result_width;
    logic [3:0]  oversample_factor;
    logic [15:0] ra, rb;
    logic [3:0]  fac [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h1, 4'h1, 4'h1};
    int error_cnt = 0, cmp_count = 0, flush_cnt = 0, hard_cnt = 0, cyc = 0;
    acf_regs dut (.*);
    acf_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
                         .lane_a(serial_out_lane_a), .lane_b(serial_out_lane_b_or_flag));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // pulse counters and hang limit
    always @(negedge clk) begin
        cyc++;
        flush_cnt += int'(accum_flush);
        hard_cnt  += int'(hard_reset_pulse);
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] w, input logic chk);
        host.frame(1'b1, w, chk, ra, rb);
    endtask
    // readback lands in the following frame
    task automatic rd(input logic [15:0] w, input logic [15:0] exp);
        host.frame(1'b0, w, 1'b0, ra, rb);
        host.frame(1'b0, 16'h0000, 1'b0, ra, rb);
        check(two_lane_mode ? {ra[15:8], rb[15:8]} : ra, exp);
    endtask
    task automatic final_report;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        config_load_ok = 1'b0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        check(16'(config_ready), 16'h0000);
        repeat (30) @(negedge clk);
        check(16'(config_ready), 16'h0001);
        rd(16'h3000, 16'h3100);
        rd(16'h3000, 16'h3100);
        wr(16'h1007, 1'b0);
        check({13'h0, power_down_mode, reference_source_select,
               resolution_boost_active}, 16'h0006);
        for (int i = 0; i < 8; i++) begin
            wr({4'h1, 3'h0, 3'(i), 6'h04}, 1'b0);
            check({12'h0, oversample_factor}, {12'h0, fac[i]});
            check({11'h0, result_width}, (i inside {[1:3]}) ? 16'h0012 : 16'h0010);
            check(16'(resolution_boost_active), (i inside {[1:3]}) ? 16'h0001 : 16'h0000);
        end
        rd(16'h1000, 16'h11C4);
        wr(16'h2F00, 1'b0);
        check(16'(two_lane_mode), 16'h0000);
        rd(16'h2000, 16'h2100);
        check(rb, 16'h0000);
        wr(16'h1008, 1'b0);
        check(16'(lane_b_is_flag), 16'h0001);
        check(16'(serial_out_lane_b_or_flag), 16'h0001);
        wr(16'h2155, 1'b0);
        check(16'(flush_cnt), 16'h0000);
        wr(16'h213C, 1'b0);
        check({hard_cnt[7:0], flush_cnt[7:0]}, 16'h0001);
        check(16'(lane_b_is_flag), 16'h0001);
        rd(16'h2000, 16'h2100);
        wr(16'h1028, 1'b1);
        wr(16'h1029, 1'b0);
        check(16'(power_down_mode), 16'h0000);
        rd(16'h3000, 16'h3300);
        rd(16'h3000, 16'h3100);
        // a second rejected write, then a checked soft reset must clear it
        wr(16'h1029, 1'b0);
        wr(16'h213C, 1'b1);
        rd(16'h3000, 16'h3100);
        config_load_ok = 1'b1;
        wr(16'h20FF, 1'b1);
        check(16'(config_ready), 16'h0000);
        check({hard_cnt[7:0], flush_cnt[7:0]}, 16'h0103);
        repeat (30) @(negedge clk);
        rd(16'h3000, 16'h3000);
        rd(16'h1000, 16'h1000);
        final_report();
    end
endmodule
